// File: hdl/tni_pkg.sv
// Package for the tinnitus noise injector: modes, widths, timing counts.
// Assumes one system clock and audio samples marked by a one-cycle strobe.
package tni_pkg;

  localparam int SAMPLE_W      = 16;
  localparam int ATTEN_W       = 4;
  localparam int SECS_W        = 5;
  localparam int SLOPE_W       = 2;
  localparam int CORNER_W      = 4;
  localparam int GAIN_W        = 8;
  localparam int GAIN_FRAC     = 6;
  localparam int LFSR_W        = 23;

  // Timing
  localparam int SAMPLE_RATE_HZ = 32000;
  localparam int PERIOD_MIN_S   = 1;
  localparam int PERIOD_MAX_S   = 30;
  localparam int PERIOD_OFF_S   = 0;

  // Noise seed and taps, sample limits
  localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h5A5A5A;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 23'h420000;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 16'h7FFF;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 16'h8000;

  // Injection point and audio enable
  typedef enum logic [2:0] {
    TNI_INJ_OFF  = 3'h0,
    TNI_INJ_PRE  = 3'h1,
    TNI_INJ_POST = 3'h2,
    TNI_INJ_NOPRE  = 3'h3,
    TNI_INJ_NOPOST = 3'h4,
    TNI_INJ_PRE_NOISEVC = 3'h5
  } tni_mode_type;

  typedef struct packed {
    logic                enable;
    tni_mode_type        mode;
    logic [ATTEN_W-1:0]  atten;
    logic                lp_en;
    logic [SLOPE_W-1:0]  lp_slope;
    logic [CORNER_W-1:0] lp_corner;
    logic                hp_en;
    logic [SLOPE_W-1:0]  hp_slope;
    logic [CORNER_W-1:0] hp_corner;
    logic [SECS_W-1:0]   on_secs;
    logic [SECS_W-1:0]   off_secs;
  } tni_cfg_type;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } tni_smp_type;

  function automatic logic [SAMPLE_W-1:0] tni_sat_add(
    input logic [SAMPLE_W-1:0] a,
    input logic [SAMPLE_W-1:0] b
  );
    logic [SAMPLE_W:0] s;
    s = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
    if (s[SAMPLE_W] != s[SAMPLE_W-1]) begin
      tni_sat_add = s[SAMPLE_W] ? SAMPLE_MIN : SAMPLE_MAX;
    end else begin
      tni_sat_add = s[SAMPLE_W-1:0];
    end
  endfunction : tni_sat_add

endpackage : tni_pkg

// File: hdl/tni_shaper.sv
// Cascade of up to four one-pole shaping sections for the treatment noise.
// Assumes samples arrive on a strobe; slope sets how many poles cascade.
`timescale 1ns/1ps
module tni_shaper
  import tni_pkg::*;
#(
  parameter int HIGH_PASS = 0
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Setting
  input  wire logic                en,
  input  wire logic [SLOPE_W-1:0]  slope,
  input  wire logic [CORNER_W-1:0] corner,
  // Stream
  input  wire tni_pkg::tni_smp_type in_smp,
  output tni_pkg::tni_smp_type      out_smp
);

  typedef struct packed {
    logic [3:0][SAMPLE_W+3:0] acc;
    tni_smp_type              out;
  } tni_shp_state_type;

  tni_shp_state_type st;
  tni_shp_state_type next_st;

  always_comb begin
    logic signed [SAMPLE_W+3:0] x;
    logic signed [SAMPLE_W+3:0] lp;
    x  = '0;
    lp = '0;
    next_st = st;
    next_st.out.valid = in_smp.valid;
    if (in_smp.valid) begin
      x = {{4{in_smp.data[SAMPLE_W-1]}}, in_smp.data};
      // Corner 0 is widest; shift keeps the pole cheap, no multiplier
      for (int i = 0; i < 4; i++) begin
        if (i <= int'(slope)) begin
          // Both terms signed, else the shift turns logical on negatives
          next_st.acc[i] = $signed(st.acc[i]) +
            ((x - $signed(st.acc[i])) >>> (int'(corner) + 1));
          lp = $signed(next_st.acc[i]);
          x  = HIGH_PASS != 0 ? x - lp : lp;
        end
      end
      next_st.out.data = en ? x[SAMPLE_W-1:0] : in_smp.data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_smp = st.out;

endmodule : tni_shaper

// File: hdl/tni_injector.sv
// Tinnitus noise injector: noise source, attenuation, shaping, duty cycle,
// and summing into the audio path before or after the volume stage.
// Assumes the surrounding path supplies 32 kHz samples with one-cycle
// strobes on clk_sys, and the volume stage gain in Q2.6 from the same clock.
`timescale 1ns/1ps
module tni_injector
  import tni_pkg::*;
#(
  parameter int SAMPLES_PER_SEC = SAMPLE_RATE_HZ
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Configuration
  input  wire tni_pkg::tni_cfg_type  cfg,
  // Volume stage gain, unsigned Q2.6
  input  wire logic [GAIN_W-1:0]     vol_gain,
  // Audio after the wideband gain stage
  input  wire tni_pkg::tni_smp_type  pre_in,
  // Audio after the final post filter
  input  wire tni_pkg::tni_smp_type  post_in,
  // Toward the volume stage
  output tni_pkg::tni_smp_type       vol_out,
  // Toward the peak clipper
  output tni_pkg::tni_smp_type       clip_out,
  // Status
  output logic                       noise_on,
  output logic                       low_power
);

  localparam int SEC_CNT_W = $clog2(SAMPLES_PER_SEC + 1);

  typedef struct packed {
    logic [LFSR_W-1:0]    lfsr;
    tni_smp_type          raw;
    logic                 was_en;
    logic                 phase_on;
    logic [SEC_CNT_W-1:0] smp_cnt;
    logic [SECS_W-1:0]    sec_cnt;
    tni_smp_type          vol_out;
    tni_smp_type          clip_out;
    logic                 noise_on;
    logic                 low_power;
  } tni_state_type;

  tni_state_type st;
  tni_state_type next_st;
  tni_smp_type   lp_smp;
  tni_smp_type   hp_smp;

  tni_shaper #(.HIGH_PASS(0)) u_lp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .en      (cfg.lp_en),
    .slope   (cfg.lp_slope),
    .corner  (cfg.lp_corner),
    .in_smp  (st.raw),
    .out_smp (lp_smp)
  );

  tni_shaper #(.HIGH_PASS(1)) u_hp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .en      (cfg.hp_en),
    .slope   (cfg.hp_slope),
    .corner  (cfg.hp_corner),
    .in_smp  (lp_smp),
    .out_smp (hp_smp)
  );

  // Volume scaling with saturation back to the word range
  function automatic logic [SAMPLE_W-1:0] scale(
    input logic [SAMPLE_W-1:0] s,
    input logic [GAIN_W-1:0]   g
  );
    logic signed [SAMPLE_W+GAIN_W:0] p;
    logic signed [SAMPLE_W+GAIN_W:0] q;
    p = $signed(s) * $signed({1'b0, g});
    q = p >>> GAIN_FRAC;
    if (q > $signed({{(GAIN_W+1){1'b0}}, SAMPLE_MAX})) begin
      scale = SAMPLE_MAX;
    end else if (q < $signed({{(GAIN_W+1){1'b1}}, SAMPLE_MIN})) begin
      scale = SAMPLE_MIN;
    end else begin
      scale = q[SAMPLE_W-1:0];
    end
  endfunction : scale

  // What each mode asks of the two summing points
  typedef struct packed {
    logic audio_en;
    logic pre_inj;
    logic post_inj;
    logic nz_vc_only;
  } tni_route_type;

  function automatic tni_route_type decode_mode(
    input tni_mode_type mode,
    input logic         enable
  );
    tni_route_type r;
    r          = '0;
    r.audio_en = 1'b1;
    case (mode)
      TNI_INJ_OFF: begin
      end
      TNI_INJ_PRE: begin
        r.pre_inj = 1'b1;
      end
      TNI_INJ_POST: begin
        r.post_inj = 1'b1;
      end
      TNI_INJ_NOPRE: begin
        r.pre_inj  = 1'b1;
        r.audio_en = 1'b0;
      end
      TNI_INJ_NOPOST: begin
        r.post_inj = 1'b1;
        r.audio_en = 1'b0;
      end
      TNI_INJ_PRE_NOISEVC: begin
        r.pre_inj    = 1'b1;
        r.nz_vc_only = 1'b1;
      end
      // Unused codes inject nothing and leave the audio alone
      default: begin
      end
    endcase
    if (!enable) begin
      r.pre_inj  = 1'b0;
      r.post_inj = 1'b0;
    end
    return r;
  endfunction : decode_mode

  // Galois step of the noise register. An all-zero register would stick
  // for good, so it is reseeded; costs one compare, saves a dead source.
  function automatic logic [LFSR_W-1:0] lfsr_step(
    input logic [LFSR_W-1:0] r
  );
    if (r == '0) begin
      lfsr_step = LFSR_SEED;
    end else if (r[0]) begin
      lfsr_step = (r >> 1) ^ LFSR_TAPS;
    end else begin
      lfsr_step = r >> 1;
    end
  endfunction : lfsr_step

  // Period settings outside one to thirty seconds are pulled to the
  // nearest end, so a stray value never stalls or stretches the cycle.
  // A zero off period never gets here: it stops duty cycling first.
  function automatic logic [SECS_W-1:0] clamp_secs(
    input logic [SECS_W-1:0] secs
  );
    if (secs < SECS_W'(PERIOD_MIN_S)) begin
      clamp_secs = SECS_W'(PERIOD_MIN_S);
    end else if (secs > SECS_W'(PERIOD_MAX_S)) begin
      clamp_secs = SECS_W'(PERIOD_MAX_S);
    end else begin
      clamp_secs = secs;
    end
  endfunction : clamp_secs

  always_comb begin
    logic [SAMPLE_W-1:0] nz;
    logic                audio_en;
    logic                pre_inj;
    logic                post_inj;
    logic                nz_vc_only;
    logic [SECS_W-1:0]   period;
    tni_route_type       rt;
    nz         = '0;
    rt         = '0;
    audio_en   = 1'b1;
    pre_inj    = 1'b0;
    post_inj   = 1'b0;
    nz_vc_only = 1'b0;
    period     = '0;
    next_st    = st;

    rt         = decode_mode(cfg.mode, cfg.enable);
    audio_en   = rt.audio_en;
    pre_inj    = rt.pre_inj;
    post_inj   = rt.post_inj;
    nz_vc_only = rt.nz_vc_only;

    // Noise source steps once per sample
    if (pre_in.valid) begin
      next_st.lfsr = lfsr_step(st.lfsr);
      next_st.raw.data = $signed(st.lfsr[SAMPLE_W-1:0]) >>>
                         cfg.atten;
    end
    next_st.raw.valid = pre_in.valid;

    // Duty cycle, counted in samples so it tracks the audio rate
    next_st.was_en = cfg.enable;
    period = clamp_secs(st.phase_on ? cfg.on_secs : cfg.off_secs);
    if (cfg.enable && !st.was_en) begin
      next_st.phase_on = 1'b1;
      next_st.smp_cnt  = '0;
      next_st.sec_cnt  = '0;
    end else if (cfg.off_secs == SECS_W'(PERIOD_OFF_S)) begin
      next_st.phase_on = 1'b1;
      next_st.smp_cnt  = '0;
      next_st.sec_cnt  = '0;
    end else if (pre_in.valid) begin
      if (st.smp_cnt == SEC_CNT_W'(SAMPLES_PER_SEC - 1)) begin
        next_st.smp_cnt = '0;
        if (st.sec_cnt + 1'b1 >= period) begin
          next_st.sec_cnt  = '0;
          next_st.phase_on = !st.phase_on;
        end else begin
          next_st.sec_cnt = st.sec_cnt + 1'b1;
        end
      end else begin
        next_st.smp_cnt = st.smp_cnt + 1'b1;
      end
    end

    nz = (st.phase_on && cfg.enable) ? hp_smp.data : '0;

    // Pre-volume point, ahead of the volume stage
    next_st.vol_out.valid = pre_in.valid;
    if (pre_in.valid) begin
      if (!audio_en) begin
        next_st.vol_out.data = pre_inj ? nz : '0;
      end else if (pre_inj && nz_vc_only) begin
        // Audio passes unaltered here; the noise joins after the stage, scaled by vol_gain
        next_st.vol_out.data = pre_in.data;
      end else if (pre_inj) begin
        next_st.vol_out.data = tni_sat_add(pre_in.data, nz);
      end else begin
        next_st.vol_out.data = pre_in.data;
      end
    end

    // Post-volume point, ahead of the peak clipper
    next_st.clip_out.valid = post_in.valid;
    if (post_in.valid) begin
      if (pre_inj && nz_vc_only) begin
        next_st.clip_out.data = tni_sat_add(post_in.data,
                                            scale(nz, vol_gain));
      end else if (post_inj) begin
        next_st.clip_out.data =
          tni_sat_add(audio_en ? post_in.data : '0, nz);
      end else begin
        next_st.clip_out.data = post_in.data;
      end
    end

    next_st.noise_on  = cfg.enable && st.phase_on && (pre_inj || post_inj);
    next_st.low_power = !audio_en && cfg.enable;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.lfsr     <= LFSR_SEED;
      st.phase_on <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign vol_out   = st.vol_out;
  assign clip_out  = st.clip_out;
  assign noise_on  = st.noise_on;
  assign low_power = st.low_power;

endmodule : tni_injector

// File: testbench/tni_injector_properties.sv
// Port checker for the tinnitus noise injector.
// Assumes it is bound to tni_injector and sees only its ports.
`timescale 1ns/1ps
module tni_checker
  import tni_pkg::*;
#(
  parameter int SAMPLES_PER_SEC = 4
) (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rst,
  // Inputs
  input wire tni_pkg::tni_cfg_type cfg,
  input wire logic [GAIN_W-1:0]    vol_gain,
  input wire tni_pkg::tni_smp_type pre_in,
  input wire tni_pkg::tni_smp_type post_in,
  // Outputs
  input wire tni_pkg::tni_smp_type vol_out,
  input wire tni_pkg::tni_smp_type clip_out,
  input wire logic                 noise_on,
  input wire logic                 low_power
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_pre;
    pre_in.valid;
  endsequence
  sequence s_post;
    post_in.valid;
  endsequence
  a_vol_latency: assert property (s_pre |=> vol_out.valid)
    else $error("vol_out strobe missing");
  a_clip_latency: assert property (s_post |=> clip_out.valid)
    else $error("clip_out strobe missing");
  a_vol_cause: assert property (vol_out.valid |-> $past(pre_in.valid))
    else $error("vol_out strobe without sample");
  a_clip_cause: assert property (clip_out.valid |-> $past(post_in.valid))
    else $error("clip_out strobe without sample");
  a_low_power: assert property (!$past(rst) && $stable(cfg) |->
    low_power == (cfg.enable && cfg.mode inside {3'h3, 3'h4}))
    else $error("low_power wrong for mode");
  a_vol_pass: assert property (pre_in.valid &&
    cfg.mode inside {TNI_INJ_OFF, TNI_INJ_POST}
    |=> vol_out.data == $past(pre_in.data))
    else $error("pre audio altered");
  a_clip_pass: assert property (post_in.valid &&
    cfg.mode inside {TNI_INJ_OFF, TNI_INJ_PRE}
    |=> clip_out.data == $past(post_in.data))
    else $error("post audio altered");
  a_gate_off: assert property (!cfg.enable || cfg.mode == TNI_INJ_OFF
    |=> !noise_on)
    else $error("noise_on while not injecting");
  a_sat_high: assert property (pre_in.valid && pre_in.data == SAMPLE_MAX &&
    cfg.mode == TNI_INJ_PRE |=> !vol_out.data[SAMPLE_W-1] || &vol_out.data)
    else $error("sum wrapped");
endmodule : tni_checker

bind tni_injector tni_checker #(.SAMPLES_PER_SEC(SAMPLES_PER_SEC)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .cfg(cfg), .vol_gain(vol_gain),
  .pre_in(pre_in), .post_in(post_in), .vol_out(vol_out),
  .clip_out(clip_out), .noise_on(noise_on), .low_power(low_power));

// File: testbench/tni_vol_stage.sv
// Volume stage model: scales vol_out by vol_gain, returns it as post_in.
// Assumes Q2.6 gain and one register of delay.
`timescale 1ns/1ps
module tni_vol_stage
  import tni_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // From the injector
  input  wire logic [GAIN_W-1:0]    vol_gain,
  input  wire tni_pkg::tni_smp_type vol_out,
  // Toward the post point
  output tni_pkg::tni_smp_type      post_in
);
  int x;
  always_comb begin
    x = ($signed(vol_out.data) * int'(vol_gain)) >>> GAIN_FRAC;
    if (x > 32767) x = 32767;
    if (x < -32768) x = -32768;
  end
  // Data toggles between strobes so a stale word never passes as valid
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      post_in <= '0;
    end else begin
      post_in.valid <= vol_out.valid;
      post_in.data  <= vol_out.valid ? x[15:0] : ~post_in.data;
    end
  end
endmodule : tni_vol_stage

// File: testbench/tni_injector_test.sv
// Testbench for the noise injector: every mode with duty cycling.
// Assumes the volume stage model closes vol_out back to post_in.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  n_mismatch++; $display("Error %0t: got %h want %h", $time, a, b); \
  end end
module tni_injector_test;
  import tni_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  tni_cfg_type       cfg = '0;
  logic [GAIN_W-1:0] vol_gain = 8'h40;
  tni_smp_type       pre_in = '0;
  tni_smp_type       post_in, vol_out, clip_out;
  logic              noise_on, low_power;
  int n_mismatch = 0, comparisons = 0, cyc = 0, k, m, seed = 32'h4767;

  tni_injector #(.SAMPLES_PER_SEC(4)) dut (.clk_sys(clk_sys), .rst(rst),
    .cfg(cfg), .vol_gain(vol_gain), .pre_in(pre_in), .post_in(post_in),
    .vol_out(vol_out), .clip_out(clip_out), .noise_on(noise_on),
    .low_power(low_power));
  tni_vol_stage u_vol (.clk_sys(clk_sys), .rst(rst), .vol_gain(vol_gain),
    .vol_out(vol_out), .post_in(post_in));

  function automatic logic [SAMPLE_W-1:0] vst(input logic [SAMPLE_W-1:0] v);
    int x;
    x = ($signed(v) * int'(vol_gain)) >>> GAIN_FRAC;
    if (x > 32767) x = 32767;
    if (x < -32768) x = -32768;
    return x[15:0];
  endfunction : vst

  // Compares data only on mid-second samples; phase edges may shift by one strobe
  task automatic smp(input logic [SAMPLE_W-1:0] d);
    logic [SAMPLE_W-1:0] ev;
    logic on, sure, kv;
    // Step off the edge so registered outputs have settled
    #1;
    on = cfg.off_secs == 5'h00 || (k / 4) % 2 == 0;
    sure = k % 4 == 1 || k % 4 == 2;
    if (k % 4 == 2) begin
      `CHK(noise_on, cfg.mode inside {[1:5]} && on)
      `CHK(low_power, cfg.mode inside {3, 4})
    end
    ev = (cfg.mode inside {3, 4}) ? '0 : d;
    kv = sure && (cfg.mode inside {0, 2, 4, 5} ||
                  (cfg.mode inside {1, 3} && !on));
    @(posedge clk_sys);
    pre_in <= '{1'b1, d};
    @(posedge clk_sys);
    pre_in.valid <= 1'b0;
    #1;
    `CHK(vol_out.valid, 1'b1)
    if (kv) `CHK(vol_out.data, ev)
    if (cfg.mode == 1 && on && sure && d inside {16'h7FFF, 16'h8000})
      `CHK(vol_out.data[15] == d[15] || &vol_out.data, 1'b1)
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(clip_out.valid, 1'b1)
    if (kv && (cfg.mode inside {0, 1, 3} || !on)) `CHK(clip_out.data, vst(ev))
    if (cfg.mode == 4 && sure && !on) `CHK(clip_out.data, 16'h0000)
    repeat (3) @(posedge clk_sys);
  endtask : smp

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (m = 0; m < 7; m++) begin
      @(posedge clk_sys);
      cfg <= tni_cfg_type'($random(seed));
      vol_gain <= 8'($random(seed));
      @(posedge clk_sys);
      cfg.enable <= 1'b0;
      cfg.mode <= tni_mode_type'(m == 6 ? 1 : m);
      cfg.on_secs <= 5'h01;
      cfg.off_secs <= (m == 6) ? 5'h00 : 5'h01;
      if (m == 1) cfg.atten <= 4'h0;
      @(posedge clk_sys);
      cfg.enable <= 1'b1;
      k = 0;
      repeat (16) begin
        smp(k % 8 == 1 ? 16'h7FFF : k % 8 == 2 ? 16'h8000 : 16'($random(seed)));
        k++;
      end
      $display("test %0d done", m);
    end
    final_report();
  end
endmodule : tni_injector_test
